// file: core/tasl_core.sv
// Operation
// [R1] Wait programmed first-conversion delay before touch channels and sequence start.
// [R2] Config bit 15 set stops temperature results from raising the interrupt.
// [R3] Config bit 14 set stops auxiliary/battery results from raising the interrupt.
// [R4] Config bit 13 picks data-ready (0) or limit-alert (1) interrupt behaviour.
// [R5] General-purpose pin mask bit: 0 lets the pin alert, 1 suppresses.
// [R6] Config bits 10, 9, 8 report supply-high, temp-low, temp-high limit status.
// [R7] Four 16-bit writable limit registers at 0x04 to 0x07, reset zero.
// [R8] Config bits 7 to 1 select Y, X, Z1, Z2, aux, battery, temp.
// [R9] General-purpose pin enabled skips both auxiliary and battery channels.
// [R10] Auxiliary and battery both selected, pin disabled: measure battery only.
// [R11] Six read-only result registers 0x08 to 0x0D, reset zero, fixed order.
// [R12] Identity register 0x0E: revision in 11:8, identifier in 7:0, top zero.
// [R13] Limit-alert mode asserts interrupt while an unmasked result exceeds limits.
// [R14] Host writes channel selection before starting a slave-mode sequence.
// [R15] Supply and temperature results compared with limits when written; flags updated.
`timescale 1ns/1ns
`default_nettype none

module tasl_core
    import tasl_pkg::*;
#(
    parameter int FCD_STEP_CYCLES = TASL_FCD_STEP_CYCLES,
    parameter logic [3:0] REVISION = 4'h1,
    // Arbitrary identity value
    parameter logic [7:0] DEVICE_ID = 8'h5a
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_reg,
    output logic reg_rvalid_reg,
    input wire logic seq_start,
    input wire logic [3:0] first_convert_delay,
    input wire logic gpio_enable,
    input wire logic gpio_alert,
    output logic conv_req_reg,
    output logic [2:0] conv_channel_reg,
    input wire logic conv_done,
    input wire logic [15:0] conv_data,
    output logic seq_busy_reg,
    output logic irq_n_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [2:0] first_set(input logic [TASL_NUM_CH-1:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = TASL_NUM_CH - 1; i >= 0; i--)
        begin
            if (m[i])
                idx = 3'(i);
        end
        return idx;
    endfunction

    function automatic logic [2:0] slot_of(input logic [2:0] ch);
        logic [2:0] s;
        s = ch;
        if (ch == TASL_CH_AUX || ch == TASL_CH_BATT)
            s = TASL_SLOT_SUPPLY;
        else if (ch == TASL_CH_TEMP)
            s = TASL_SLOT_TEMP;
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [15:0] cfg_reg;
    logic [15:0] aux_hi_reg;
    logic [15:0] aux_lo_reg;
    logic [15:0] temp_hi_reg;
    logic [15:0] temp_lo_reg;
    logic aux_high_flag_reg;
    logic temp_low_flag_reg;
    logic temp_high_flag_reg;
    logic data_pend_reg;

    tasl_state_e state_reg;
    tasl_state_e state_next;
    logic [TASL_NUM_CH-1:0] todo_reg;
    logic [TASL_NUM_CH-1:0] todo_next;
    logic [2:0] cur_ch_reg;
    logic [2:0] cur_ch_next;
    logic first_reg;
    logic first_next;
    logic [TASL_DELAY_W-1:0] delay_cnt_reg;
    logic [TASL_DELAY_W-1:0] delay_cnt_next;

    logic rd_d1_reg;
    logic [3:0] addr_d1_reg;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire logic wr_cfg = reg_wr && reg_addr == TASL_ADDR_CFG;
    wire logic wr_aux_hi = reg_wr && reg_addr == TASL_ADDR_AUX_HI;
    wire logic wr_aux_lo = reg_wr && reg_addr == TASL_ADDR_AUX_LO;
    wire logic wr_temp_hi = reg_wr && reg_addr == TASL_ADDR_TEMP_HI;
    wire logic wr_temp_lo = reg_wr && reg_addr == TASL_ADDR_TEMP_LO;
    wire logic addr_d1_is_res = addr_d1_reg >= TASL_ADDR_RES_FIRST
        && addr_d1_reg <= TASL_ADDR_RES_LAST;
    wire logic rd_result = reg_rd && reg_addr >= TASL_ADDR_RES_FIRST
        && reg_addr <= TASL_ADDR_RES_LAST;
    wire logic [2:0] rd_slot = 3'(reg_addr - TASL_ADDR_RES_FIRST);

    // Selection bits 7..1 map to channels 0..6 in reversed order
    logic [TASL_NUM_CH-1:0] sel_raw;
    genvar gi;
    generate
        for (gi = 0; gi < TASL_NUM_CH; gi++)
        begin : g_sel
            assign sel_raw[gi] = cfg_reg[TASL_SEL_MSB - gi]; // see [R8]
        end
    endgenerate

    wire logic sel_aux = sel_raw[TASL_CH_AUX];
    wire logic sel_batt = sel_raw[TASL_CH_BATT];
    // Pin function steals the shared input, so neither analog use is possible
    wire logic keep_aux = sel_aux && !gpio_enable && !sel_batt; // see [R9] see [R10]
    wire logic keep_batt = sel_batt && !gpio_enable; // see [R9]
    logic [TASL_NUM_CH-1:0] sel_eff;
    assign sel_eff = {sel_raw[TASL_CH_TEMP], keep_batt, keep_aux,
                      sel_raw[TASL_CH_PRESS2:TASL_CH_YPOS]};

    wire logic [2:0] next_ch = first_set(todo_reg);
    wire logic touch_ch = next_ch <= TASL_CH_PRESS2;
    wire logic need_delay = touch_ch || first_reg; // see [R1]
    wire logic [TASL_DELAY_W-1:0] delay_target =
        TASL_DELAY_W'((TASL_DELAY_W'(first_convert_delay) + TASL_DELAY_W'(1))
        * TASL_DELAY_W'(FCD_STEP_CYCLES) - TASL_DELAY_W'(1)); // see [R1]

    wire logic res_wr = state_reg == TASL_WAIT && conv_done;
    wire logic [2:0] res_slot = slot_of(cur_ch_reg);
    wire logic seq_end = state_reg == TASL_FINISH;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb
    begin
        state_next = state_reg;
        todo_next = todo_reg;
        cur_ch_next = cur_ch_reg;
        first_next = first_reg;
        delay_cnt_next = delay_cnt_reg;
        case (state_reg)
            TASL_IDLE:
            begin
                // Selection is sampled at start; later edits wait for next start
                if (seq_start) // see [R14]
                begin
                    todo_next = sel_eff;
                    first_next = 1'b1;
                    state_next = TASL_PICK;
                end
            end
            TASL_PICK:
            begin
                delay_cnt_next = '0;
                if (todo_reg == '0)
                    state_next = TASL_FINISH;
                else
                begin
                    cur_ch_next = next_ch;
                    todo_next = todo_reg & ~(TASL_NUM_CH'(1) << next_ch);
                    state_next = need_delay ? TASL_SETTLE : TASL_REQ; // see [R1]
                end
            end
            TASL_SETTLE:
            begin
                if (delay_cnt_reg >= delay_target) // see [R1]
                    state_next = TASL_REQ;
                else
                    delay_cnt_next = delay_cnt_reg + TASL_DELAY_W'(1);
            end
            TASL_REQ:
            begin
                first_next = 1'b0;
                state_next = TASL_WAIT;
            end
            TASL_WAIT:
            begin
                if (conv_done)
                    state_next = TASL_PICK;
            end
            TASL_FINISH:
            begin
                state_next = TASL_IDLE;
            end
            default:
            begin
                state_next = TASL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= TASL_IDLE;
            todo_reg <= '0;
            cur_ch_reg <= 3'h0;
            first_reg <= 1'b0;
            delay_cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            todo_reg <= todo_next;
            cur_ch_reg <= cur_ch_next;
            first_reg <= first_next;
            delay_cnt_reg <= delay_cnt_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            conv_req_reg <= 1'b0;
            conv_channel_reg <= 3'h0;
            seq_busy_reg <= 1'b0;
        end
        else
        begin
            conv_req_reg <= state_next == TASL_REQ;
            conv_channel_reg <= cur_ch_next;
            seq_busy_reg <= state_next != TASL_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host registers

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cfg_reg <= TASL_CFG_RESET;
        else if (wr_cfg)
            cfg_reg <= reg_wdata & TASL_CFG_WR_MASK; // see [R8]
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            aux_hi_reg <= TASL_LIMIT_RESET; // see [R7]
            aux_lo_reg <= TASL_LIMIT_RESET;
            temp_hi_reg <= TASL_LIMIT_RESET;
            temp_lo_reg <= TASL_LIMIT_RESET;
        end
        else
        begin
            if (wr_aux_hi)
                aux_hi_reg <= reg_wdata; // see [R7]
            if (wr_aux_lo)
                aux_lo_reg <= reg_wdata;
            if (wr_temp_hi)
                temp_hi_reg <= reg_wdata;
            if (wr_temp_lo)
                temp_lo_reg <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit status, refreshed by each matching result

    wire logic aux_above = conv_data > aux_hi_reg; // see [R15]
    wire logic temp_below = conv_data < temp_lo_reg; // see [R15]
    wire logic temp_above = conv_data > temp_hi_reg; // see [R15]

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            aux_high_flag_reg <= 1'b0;
            temp_low_flag_reg <= 1'b0;
            temp_high_flag_reg <= 1'b0;
        end
        else if (res_wr)
        begin
            if (res_slot == TASL_SLOT_SUPPLY)
                aux_high_flag_reg <= aux_above; // see [R6] see [R15]
            if (res_slot == TASL_SLOT_TEMP)
            begin
                temp_low_flag_reg <= temp_below; // see [R6] see [R15]
                temp_high_flag_reg <= temp_above; // see [R6] see [R15]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared interrupt output

    wire logic temp_alert = !cfg_reg[TASL_BIT_TEMP_MASK]
        && (temp_low_flag_reg || temp_high_flag_reg); // see [R2]
    wire logic aux_alert = !cfg_reg[TASL_BIT_AUX_MASK] && aux_high_flag_reg; // see [R3]
    wire logic pin_alert = !cfg_reg[TASL_BIT_GPIO_MASK] && gpio_alert; // see [R5]
    wire logic limit_alert = temp_alert || aux_alert || pin_alert; // see [R13]
    wire logic int_mode = cfg_reg[TASL_BIT_INT_MODE];

    // A new sequence end wins over a result read in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            data_pend_reg <= 1'b0;
        else if (seq_end)
            data_pend_reg <= 1'b1;
        else if (rd_result)
            data_pend_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            irq_n_reg <= 1'b1;
        else if (int_mode)
            irq_n_reg <= !limit_alert; // see [R4] see [R13]
        else
            irq_n_reg <= !(data_pend_reg || seq_end); // see [R4]
    end

    ////////////////////////////////////////////////////////////////////////
    // Results and read path

    logic [15:0] res_rd_data;

    tasl_result_mem #(
        .DEPTH(TASL_NUM_SLOTS),
        .WIDTH(16)
    ) u_results (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(res_wr), // see [R11]
        .wr_slot(res_slot),
        .wr_data(conv_data),
        .rd_slot(rd_slot),
        .rd_data_reg(res_rd_data)
    );

    wire logic [15:0] cfg_view = {cfg_reg[15:11], aux_high_flag_reg,
        temp_low_flag_reg, temp_high_flag_reg, cfg_reg[7:1], 1'b0}; // see [R6]

    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        if (addr_d1_is_res)
            rd_mux = res_rd_data; // see [R11]
        else
        begin
            case (addr_d1_reg)
                TASL_ADDR_CFG: rd_mux = cfg_view;
                TASL_ADDR_AUX_HI: rd_mux = aux_hi_reg;
                TASL_ADDR_AUX_LO: rd_mux = aux_lo_reg;
                TASL_ADDR_TEMP_HI: rd_mux = temp_hi_reg;
                TASL_ADDR_TEMP_LO: rd_mux = temp_lo_reg;
                TASL_ADDR_ID: rd_mux = {4'h0, REVISION, DEVICE_ID}; // see [R12]
                default: rd_mux = 16'h0000;
            endcase
        end
    end

    // Two-cycle read keeps the result store's output registered
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rd_d1_reg <= 1'b0;
            addr_d1_reg <= 4'h0;
            reg_rdata_reg <= 16'h0000;
            reg_rvalid_reg <= 1'b0;
        end
        else
        begin
            rd_d1_reg <= reg_rd;
            addr_d1_reg <= reg_addr;
            reg_rvalid_reg <= rd_d1_reg;
            if (rd_d1_reg)
                reg_rdata_reg <= rd_mux;
        end
    end

endmodule

`default_nettype wire

// file: core/tasl_pkg.sv
package tasl_pkg;

    // Register offsets
    localparam logic [3:0] TASL_ADDR_CFG = 4'h3;
    localparam logic [3:0] TASL_ADDR_AUX_HI = 4'h4;
    localparam logic [3:0] TASL_ADDR_AUX_LO = 4'h5;
    localparam logic [3:0] TASL_ADDR_TEMP_HI = 4'h6;
    localparam logic [3:0] TASL_ADDR_TEMP_LO = 4'h7;
    localparam logic [3:0] TASL_ADDR_RES_FIRST = 4'h8;
    localparam logic [3:0] TASL_ADDR_RES_LAST = 4'hd;
    localparam logic [3:0] TASL_ADDR_ID = 4'he;

    // Field positions in sequence_and_alert_config
    localparam int TASL_BIT_TEMP_MASK = 15;
    localparam int TASL_BIT_AUX_MASK = 14;
    localparam int TASL_BIT_INT_MODE = 13;
    localparam int TASL_BIT_GPIO_MASK = 12;
    localparam int TASL_BIT_AUX_HIGH = 10;
    localparam int TASL_BIT_TEMP_LOW = 9;
    localparam int TASL_BIT_TEMP_HIGH = 8;
    localparam int TASL_SEL_MSB = 7;
    localparam int TASL_SEL_LSB = 1;
    localparam logic [15:0] TASL_CFG_WR_MASK = 16'hf0fe;

    // Reset values
    localparam logic [15:0] TASL_CFG_RESET = 16'h0000;
    localparam logic [15:0] TASL_LIMIT_RESET = 16'h0000;
    localparam logic [15:0] TASL_RESULT_RESET = 16'h0000;

    // Channel indices, in selection order
    localparam logic [2:0] TASL_CH_YPOS = 3'h0;
    localparam logic [2:0] TASL_CH_PRESS2 = 3'h3;
    localparam logic [2:0] TASL_CH_AUX = 3'h4;
    localparam logic [2:0] TASL_CH_BATT = 3'h5;
    localparam logic [2:0] TASL_CH_TEMP = 3'h6;
    localparam int TASL_NUM_CH = 7;

    // Result slots
    localparam logic [2:0] TASL_SLOT_SUPPLY = 3'h4;
    localparam logic [2:0] TASL_SLOT_TEMP = 3'h5;
    localparam int TASL_NUM_SLOTS = 6;

    // Timing: first conversion delay step
    localparam int TASL_CLK_PERIOD_NS = 10;
    localparam int TASL_FCD_STEP_NS = 128000;
    localparam int TASL_FCD_STEP_CYCLES =
        (TASL_FCD_STEP_NS + TASL_CLK_PERIOD_NS - 1) / TASL_CLK_PERIOD_NS;
    localparam int TASL_DELAY_W = 20;

    typedef enum logic [2:0] {
        TASL_IDLE,
        TASL_PICK,
        TASL_SETTLE,
        TASL_REQ,
        TASL_WAIT,
        TASL_FINISH
    } tasl_state_e;

endpackage

// file: core/tasl_result_mem.sv
`timescale 1ns/1ns
`default_nettype none

module tasl_result_mem
    import tasl_pkg::*;
#(
    parameter int DEPTH = TASL_NUM_SLOTS,
    parameter int WIDTH = 16
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [2:0] wr_slot,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [2:0] rd_slot,
    output logic [WIDTH-1:0] rd_data_reg
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // Reset clears every slot so reads before a sequence return zero
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_slot
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                    mem_reg[gi] <= TASL_RESULT_RESET;
                else if (wr_en && wr_slot == 3'(gi))
                    mem_reg[gi] <= wr_data;
            end
        end
    endgenerate

    wire logic rd_in_range = int'(rd_slot) < DEPTH;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            rd_data_reg <= TASL_RESULT_RESET;
        else
            rd_data_reg <= rd_in_range ? mem_reg[rd_slot] : TASL_RESULT_RESET;
    end

endmodule

`default_nettype wire

// file: tb/tasl_conv_model.sv
`timescale 1ns/1ns
`default_nettype none

module tasl_conv_model
(
    input wire logic sys_clk,
    input wire logic conv_req,
    input wire logic [2:0] conv_channel,
    input wire logic [3:0] lat,
    input wire logic [15:0] ch_value [7],
    output logic conv_done,
    output logic [15:0] conv_data
);
    logic pend_reg = 1'b0;
    logic [3:0] cnt_reg = 4'h0;
    logic [2:0] ch_reg = 3'h0;
    initial conv_done = 1'b0;
    initial conv_data = 16'h0000;

    // Data toggles outside its valid cycle so a late sample cannot pass
    always @(posedge sys_clk)
    begin
        conv_done <= 1'b0;
        if (conv_req)
        begin
            pend_reg <= 1'b1;
            cnt_reg <= lat;
            ch_reg <= conv_channel;
        end
        else if (pend_reg && cnt_reg == 4'h0)
        begin
            conv_done <= 1'b1;
            conv_data <= ch_value[ch_reg];
            pend_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg - 4'h1;
            conv_data <= ~conv_data;
        end
    end
endmodule

`default_nettype wire

// file: tb/tasl_core_chk.sv
`timescale 1ns/1ns
`default_nettype none

module tasl_core_chk
    import tasl_pkg::*;
#(
    parameter int FCD_STEP_CYCLES = 4
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_reg,
    input wire logic reg_rvalid_reg,
    input wire logic seq_start,
    input wire logic gpio_enable,
    input wire logic conv_req_reg,
    input wire logic [2:0] conv_channel_reg,
    input wire logic seq_busy_reg,
    input wire logic irq_n_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////
    // Last requested channel, so order within a sequence can be judged
    logic seen_reg;
    logic [2:0] last_ch_reg;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !seq_busy_reg)
            seen_reg <= 1'b0;
        else if (conv_req_reg)
            seen_reg <= 1'b1;
        if (conv_req_reg)
            last_ch_reg <= conv_channel_reg;
    end

    ////////////////////////////////////////
    a_req_pulse: assert property (conv_req_reg |=> !conv_req_reg)
        else $error("conversion request longer than one cycle");
    a_rd_answer: assert property (reg_rd |-> ##2 reg_rvalid_reg)
        else $error("read answer missing two cycles after strobe");
    a_rd_quiet: assert property (!reg_rd |-> ##2 !reg_rvalid_reg)
        else $error("read valid without a read strobe");
    a_rdata_hold: assert property (!reg_rvalid_reg |-> $stable(reg_rdata_reg))
        else $error("read data moved without a read answer");
    a_start_busy: assert property (seq_start && !seq_busy_reg |=> seq_busy_reg)
        else $error("sequence start did not raise busy");
    a_first_delay: assert property (seq_start && !seq_busy_reg |=> (!conv_req_reg)[*5])
        else $error("first conversion requested before settling delay");
    a_req_in_seq: assert property (conv_req_reg |-> seq_busy_reg)
        else $error("conversion request outside a sequence");
    a_gpio_skip: assert property (conv_req_reg && gpio_enable |->
        conv_channel_reg != TASL_CH_AUX && conv_channel_reg != TASL_CH_BATT)
        else $error("auxiliary or battery converted with pin function on");
    a_chan_order: assert property (conv_req_reg && seen_reg |-> conv_channel_reg > last_ch_reg)
        else $error("channels not in ascending order");
    a_chan_hold: assert property (conv_req_reg |=> $stable(conv_channel_reg))
        else $error("channel changed right after its request");

    c_temp_conv: cover property (conv_req_reg && conv_channel_reg == TASL_CH_TEMP);
    c_read: cover property (reg_rvalid_reg);
    c_irq: cover property ($fell(irq_n_reg));
endmodule

bind tasl_core tasl_core_chk #(.FCD_STEP_CYCLES(FCD_STEP_CYCLES)) u_tasl_core_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
    .reg_rvalid_reg(reg_rvalid_reg), .seq_start(seq_start), .gpio_enable(gpio_enable),
    .conv_req_reg(conv_req_reg), .conv_channel_reg(conv_channel_reg),
    .seq_busy_reg(seq_busy_reg), .irq_n_reg(irq_n_reg));

`default_nettype wire

// file: tb/tasl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tasl_tb_top
    import tasl_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_rd = 1'b0;
    logic seq_start = 1'b0;
    logic [3:0] fcd = 4'h0;
    logic [3:0] lat = 4'h0;
    logic gpio_enable = 1'b0;
    logic gpio_alert = 1'b0;
    logic [15:0] reg_rdata_reg, conv_data;
    logic reg_rvalid_reg, conv_req_reg, conv_done, seq_busy_reg, irq_n_reg;
    logic [2:0] conv_channel_reg;
    logic [15:0] vals [7];
    logic [2:0] seen [$];
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int start_cyc = 0;
    int first_gap = 0;

    always #5 sys_clk = ~sys_clk;

    tasl_core #(.FCD_STEP_CYCLES(4)) u_tasl_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg), .seq_start(seq_start),
        .first_convert_delay(fcd), .gpio_enable(gpio_enable), .gpio_alert(gpio_alert),
        .conv_req_reg(conv_req_reg), .conv_channel_reg(conv_channel_reg),
        .conv_done(conv_done), .conv_data(conv_data), .seq_busy_reg(seq_busy_reg),
        .irq_n_reg(irq_n_reg));

    tasl_conv_model u_tasl_conv_model (.sys_clk(sys_clk), .conv_req(conv_req_reg),
        .conv_channel(conv_channel_reg), .lat(lat), .ch_value(vals),
        .conv_done(conv_done), .conv_data(conv_data));

    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (conv_req_reg === 1'b1)
        begin
            if (seen.size() == 0)
                first_gap = cyc - start_cyc;
            seen.push_back(conv_channel_reg);
        end
    end

    ////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        // Answer stands for one cycle only, two edges after the strobe
        @(posedge sys_clk);
        #1;
        chk({15'h0000, reg_rvalid_reg}, 16'h0001);
        chk(reg_rdata_reg, exp);
    endtask

    task irq_chk(input logic exp);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({15'h0000, irq_n_reg}, {15'h0000, exp});
    endtask

    // Waits for busy to drop, bounded so a stuck sequencer still ends the run
    task run_seq;
        int i;
        seen.delete();
        @(posedge sys_clk);
        #1;
        seq_start = 1'b1;
        start_cyc = cyc;
        @(posedge sys_clk);
        #1;
        seq_start = 1'b0;
        i = 0;
        while (seq_busy_reg !== 1'b0 && i < 2000)
        begin
            @(posedge sys_clk);
            i++;
        end
        #1;
        if (i == 2000)
            n_fail++;
    endtask

    task chk_chans(input logic [2:0] e [$]);
        chk(16'(seen.size()), 16'(e.size()));
        foreach (e[i])
            if (i < seen.size())
                chk({13'h0000, seen[i]}, {13'h0000, e[i]});
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////
    initial
    begin
        vals = '{16'h0111, 16'h0222, 16'h0333, 16'h0444, 16'h0555, 16'h0300, 16'h0250};
        repeat (4) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        for (int a = 3; a <= 13; a++)
            rd_chk(4'(a), 16'h0000);
        rd_chk(TASL_ADDR_ID, 16'h015a);
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'hf, 16'h0000);
        $display("test reset values done");
        wr(TASL_ADDR_AUX_HI, 16'h0100);
        wr(TASL_ADDR_AUX_LO, 16'h0050);
        wr(TASL_ADDR_TEMP_HI, 16'h0200);
        wr(TASL_ADDR_TEMP_LO, 16'h0100);
        rd_chk(TASL_ADDR_AUX_HI, 16'h0100);
        rd_chk(TASL_ADDR_AUX_LO, 16'h0050);
        rd_chk(TASL_ADDR_TEMP_HI, 16'h0200);
        rd_chk(TASL_ADDR_TEMP_LO, 16'h0100);
        wr(TASL_ADDR_RES_FIRST, 16'hbeef);
        rd_chk(TASL_ADDR_RES_FIRST, 16'h0000);
        wr(TASL_ADDR_CFG, 16'hffff);
        rd_chk(TASL_ADDR_CFG, 16'hf0fe);
        $display("test register access done");
        wr(TASL_ADDR_CFG, 16'h00fe);
        fcd = 4'h2;
        run_seq;
        chk(16'(first_gap >= 12), 16'h0001);
        chk_chans('{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6});
        irq_chk(1'b0);
        rd_chk(4'h8, 16'h0111);
        rd_chk(4'h9, 16'h0222);
        rd_chk(4'ha, 16'h0333);
        rd_chk(4'hb, 16'h0444);
        rd_chk(4'hc, 16'h0300);
        rd_chk(4'hd, 16'h0250);
        irq_chk(1'b1);
        rd_chk(TASL_ADDR_CFG, 16'h05fe);
        $display("test full sequence done");
        wr(TASL_ADDR_CFG, 16'h2006);
        fcd = 4'h0;
        lat = 4'h6;
        run_seq;
        chk_chans('{3'h5, 3'h6});
        irq_chk(1'b0);
        wr(TASL_ADDR_CFG, 16'ha006);
        irq_chk(1'b0);
        wr(TASL_ADDR_CFG, 16'h6006);
        irq_chk(1'b0);
        wr(TASL_ADDR_CFG, 16'he006);
        irq_chk(1'b1);
        gpio_alert = 1'b1;
        irq_chk(1'b0);
        wr(TASL_ADDR_CFG, 16'hf006);
        irq_chk(1'b1);
        gpio_alert = 1'b0;
        $display("test limit alerts done");
        gpio_enable = 1'b1;
        vals[6] = 16'h0050;
        wr(TASL_ADDR_CFG, 16'h000e);
        run_seq;
        chk_chans('{3'h6});
        rd_chk(TASL_ADDR_CFG, 16'h060e);
        rd_chk(TASL_ADDR_RES_LAST, 16'h0050);
        $display("test pin skip done");
        print_verdict;
    end

    initial
    begin
        #300000;
        n_fail++;
        print_verdict;
    end
endmodule

`default_nettype wire
